// ### shared/auxc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef AUXC_DEFINES_SVH
`define AUXC_DEFINES_SVH
`define AUXC_SFR_ADDR 8'h8E
`define AUXC_BYTE_ADDR 12'h238
`define AUXC_RESET 8'h0C
`define AUXC_WMASK 8'hAF
`define AUXC_BIT_GATE 0
`define AUXC_BIT_EXTSEL 1
`define AUXC_BIT_XRS_LO 2
`define AUXC_BIT_XRS_HI 3
`define AUXC_BIT_STRETCH 5
`define AUXC_BIT_PUDIS 7
`define AUXC_ALE_DIV_X1 3'h6
`define AUXC_ALE_DIV_X2 3'h3
`define AUXC_STROBE_SHORT 5'h06
`define AUXC_STROBE_LONG 5'h1E
`define AUXC_XRAM_UNIT 11'h100
`endif

// ### shared/auxc_pkg.sv
// types for the auxiliary control block
package auxc_pkg;
   typedef enum logic [2:0] {
      AUXC_IDLE = 3'b001,
      AUXC_LATCH = 3'b010,
      AUXC_STROBE = 3'b100
   } auxc_ext_st_t;
   typedef enum logic [1:0] {
      AUXC_XS_RD = 2'h0,
      AUXC_XS_WR = 2'h1,
      AUXC_XS_CODE = 2'h2,
      AUXC_XS_FETCH = 2'h3
   } auxc_kind_t;
endpackage

// ### verilog/auxc_aux_control.sv
// auxiliary control register with latch strobe and external strobe timing
`include "auxc_defines.svh"
// Operation
// - latch strobe demuxes port 0 addresses
// - gate clear: strobe at osc/6 or osc/3
// - gate set: strobe only on external accesses
// - suppressed strobe pin is weakly pulled high
// - read/write strobes 6 or 30 clocks
// - bit 7 disables standard port pull-ups
// - register sits at special address 8Eh
// - reset 0X0X1100b, byte access only
module auxc_aux_control (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic double_speed_mode,
   input wire logic ext_req,
   input wire auxc_pkg::auxc_kind_t ext_kind,
   input wire logic [15:0] ext_addr,
   output logic ext_ack,
   output logic ale_o,
   output logic ale_oe,
   output logic ale_pullup_en,
   output logic rd_n,
   output logic wr_n,
   output logic port0_addr_oe,
   output logic [7:0] port0_addr,
   output logic port_pullup_en,
   output logic [10:0] xram_size_bytes,
   output logic xram_select
);
   import auxc_pkg::*;

   // how the block is put together
   // the register sits behind a small AXI4-Lite slave; write address and
   // write data are captured on their own handshakes and merged once both
   // are held, so a master may present them in either order
   // reads answer one cycle after the address handshake, always from the
   // register as it stood before that edge
   // the latch strobe has two sources: a free-running divider, and the
   // latch phase of the external access sequencer
   // when the gate bit is set only the sequencer may raise the strobe, and
   // between accesses the pin is let go to its weak pull-up
   // the sequencer is a three-state walk: idle, one latch cycle with the
   // low address on port 0, then a strobe phase of 6 or 30 cycles
   // code reads and fetches walk the same path but never pull the read or
   // write strobe, since those belong to data moves only
   // the core holds its request until it samples the acknowledge; a
   // request seen while the acknowledge stands is therefore the old one
   // and is not taken again
   // limitation: the block only models timing and steering, it carries
   // no data of its own to or from the external memory

   // whole block state in one packed struct
   typedef struct packed {
      logic [7:0] aux_control;    // the register itself
      logic aw_hold;              // write address taken
      logic [11:0] aw_addr;       // captured write address
      logic w_hold;               // write data taken
      logic [7:0] w_data;         // captured low byte
      logic w_lane;               // low lane strobe seen
      logic bvalid;               // write response pending
      logic [1:0] bresp;          // write response code
      logic rvalid;               // read data pending
      logic [31:0] rdata;         // read data word
      logic [1:0] rresp;          // read response code
      logic [2:0] ale_cnt;        // free-running strobe divider
      logic ale;                  // latch strobe level
      auxc_ext_st_t st;           // external access sequencer
      logic [4:0] stb_cnt;        // strobe length counter
      auxc_kind_t kind;           // kind of access under way
      logic ack;                  // access done pulse
      logic [7:0] p0_addr;        // address shown on port 0
      logic p0_oe;                // port 0 address drive
   } auxc_state_t;

   auxc_state_t s_q;
   auxc_state_t s_d;
   logic [2:0] ale_div;
   logic [4:0] stb_len;
   logic [7:0] wr_val;
   logic wr_fire;

   // address decode shared by both bus channels
   function automatic logic auxc_hit(input logic [11:0] a);
      // word index compare; the two low byte bits are ignored
      auxc_hit = (a[11:2] == 10'(`AUXC_BYTE_ADDR >> 2));
   endfunction

   // true for data moves, which use the read or write strobe
   function automatic logic auxc_is_data(input auxc_kind_t k);
      auxc_is_data = (k == AUXC_XS_RD) || (k == AUXC_XS_WR);
   endfunction

   // next state of everything
   // every field is first copied, so a field left alone keeps its value
   // the reset branch sits last so it overrides every other assignment
   // a single process keeps the whole next state in one place, at the
   // cost of a long body; the sections below are independent of each
   // other apart from sharing the copied state
   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      // osc/6 in normal mode, osc/3 in double speed
      ale_div = double_speed_mode ? `AUXC_ALE_DIV_X2 : `AUXC_ALE_DIV_X1;
      // strobe length from the stretch bit
      stb_len = s_q.aux_control[`AUXC_BIT_STRETCH] ?
         `AUXC_STROBE_LONG : `AUXC_STROBE_SHORT;
      // reserved bits are masked so a stray one never sticks
      wr_val = s_q.w_data & `AUXC_WMASK;

      // write address and data taken in either order
      // each side is held until the other arrives; a second address is
      // refused by awready until the response has been accepted
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_hold = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_hold = 1'b1;
         s_d.w_data = s_axi_wdata[7:0];
         s_d.w_lane = s_axi_wstrb[0];
      end
      wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
      if (wr_fire) begin
         s_d.aw_hold = 1'b0;
         s_d.w_hold = 1'b0;
         s_d.bvalid = 1'b1;
         if (auxc_hit(s_q.aw_addr)) begin
            s_d.bresp = 2'h0;
            // whole byte only, a write without lane 0 is dropped
            if (s_q.w_lane) begin
               s_d.aux_control = wr_val;
            end
         end else begin
            s_d.bresp = 2'h2; // unmapped: slave error
         end
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      // read: one cycle from address to data
      // arready stays low while data waits, so a new address can never
      // overwrite data that the master has not yet taken
      if (s_axi_arvalid && s_axi_arready) begin
         s_d.rvalid = 1'b1;
         if (auxc_hit(s_axi_araddr)) begin
            s_d.rdata = {24'h000000, s_q.aux_control};
            s_d.rresp = 2'h0;
         end else begin
            s_d.rdata = 32'h00000000;
            s_d.rresp = 2'h2;
         end
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end

      // free-running latch strobe, high for the first count
      // the divider keeps running while gated, so the free strobe comes
      // back in its old phase as soon as the gate bit is cleared
      // a change of speed mode takes effect at once, since the running count is compared against the new divider
      if (s_q.ale_cnt >= ale_div - 3'h1) begin
         s_d.ale_cnt = 3'h0;
      end else begin
         s_d.ale_cnt = s_q.ale_cnt + 3'h1;
      end
      s_d.ale = (s_d.ale_cnt == 3'h0);

      // external access sequencer: latch phase then strobe phase
      // the kind is captured on entry so a change of ext_kind during the
      // access cannot switch a read strobe into a write strobe
      case (s_q.st)
         AUXC_IDLE: begin
            s_d.p0_oe = 1'b0;
            // on-chip data moves never reach the pins
            // while ack stands the request is the finished one: ignore it
            if (ext_req && !s_q.ack && !(auxc_is_data(ext_kind) &&
                !s_q.aux_control[`AUXC_BIT_EXTSEL])) begin
               s_d.st = AUXC_LATCH;
               s_d.kind = ext_kind;
               s_d.p0_addr = ext_addr[7:0];
               s_d.p0_oe = 1'b1;
            end else if (ext_req && !s_q.ack) begin
               // on-chip data move: answered at once, pins stay quiet
               s_d.ack = 1'b1;
            end
         end
         AUXC_LATCH: begin
            // address held on port 0 while the strobe latches it
            s_d.p0_oe = 1'b0;
            s_d.st = AUXC_STROBE;
            s_d.stb_cnt = 5'h00;
         end
         AUXC_STROBE: begin
            // the stretch bit is read every cycle; software should not
            // change it while a data move is under way
            if (s_q.stb_cnt == stb_len - 5'h01) begin
               s_d.st = AUXC_IDLE;
               s_d.ack = 1'b1;
            end else begin
               s_d.stb_cnt = s_q.stb_cnt + 5'h01;
            end
         end
         default: begin
            // an illegal code falls back to idle rather than locking up
            s_d.st = AUXC_IDLE;
         end
      endcase

      // synchronous reset: constants only, all valids and strobes idle
      if (!aresetn) begin
         s_d = '0;
         s_d.aux_control = `AUXC_RESET;
         s_d.st = AUXC_IDLE;
         s_d.kind = AUXC_XS_RD;
      end
   end

   // one register stage for the whole state
   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   // bus handshakes: one of each in flight
   // readies are combinational from state only, never from a valid, so no
   // loop through the master can form
   assign s_axi_awready = !s_q.aw_hold && !s_q.bvalid;
   assign s_axi_wready = !s_q.w_hold && !s_q.bvalid;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   // latch strobe: free-running, or only in the latch phase when gated
   // the pin is driven all the time when ungated, so the weak pull-up is
   // only needed, and only turned on, while the pin is released
   always_comb begin
      if (s_q.aux_control[`AUXC_BIT_GATE]) begin
         ale_o = (s_q.st == AUXC_LATCH);
      end else begin
         ale_o = s_q.ale || (s_q.st == AUXC_LATCH);
      end
      // gated and idle: release the pin to its weak pull-up
      ale_oe = !s_q.aux_control[`AUXC_BIT_GATE] ||
         (s_q.st == AUXC_LATCH);
      ale_pullup_en = !ale_oe;
   end

   // read/write strobes only during the strobe phase of data moves
   // both come straight from state flops through a compare, so they are
   // free of glitches from the bus side
   assign rd_n = !((s_q.st == AUXC_STROBE) &&
      (s_q.kind == AUXC_XS_RD));
   assign wr_n = !((s_q.st == AUXC_STROBE) &&
      (s_q.kind == AUXC_XS_WR));
   assign ext_ack = s_q.ack;
   assign port0_addr = s_q.p0_addr;
   assign port0_addr_oe = s_q.p0_oe;

   // configuration fan-out to the rest of the core
   // these follow the register directly, changing in the same cycle as the write lands
   assign port_pullup_en = !s_q.aux_control[`AUXC_BIT_PUDIS];
   // size code n gives (n+1) pages of 256 bytes
   assign xram_size_bytes = `AUXC_XRAM_UNIT *
      ({9'h000, s_q.aux_control[`AUXC_BIT_XRS_HI:`AUXC_BIT_XRS_LO]}
      + 11'h001);
   assign xram_select = !s_q.aux_control[`AUXC_BIT_EXTSEL];
endmodule

// ### sim/auxc_mem_model.sv
// external memory model: latches the low address and times strobes
module auxc_mem_model (
   input wire logic aclk,
   input wire logic ale_o,
   input wire logic ale_oe,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic port0_addr_oe,
   input wire logic [7:0] port0_addr,
   output logic [7:0] addr_q,
   output logic [7:0] len_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic low_q = 1'h0;
   wire ale_pin = ale_oe ? ale_o : 1'h1; // released pin floats high
   // latch is transparent while the pin is high and port 0 drives the address
   always @(posedge aclk) begin
      if (ale_pin && port0_addr_oe) addr_q <= port0_addr;
      if (!(rd_n && wr_n)) len_q <= low_q ? len_q + 8'h01 : 8'h01;
      low_q <= !(rd_n && wr_n);
   end
endmodule

// ### sim/auxc_aux_control_sva.sv
// timing checks on the latch strobe and external strobes
module auxc_aux_control_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic ext_req,
   input wire logic ext_ack,
   input wire logic ale_o,
   input wire logic ale_oe,
   input wire logic ale_pullup_en,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic port0_addr_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [5:0] low_q; // run length of a low strobe
   always_ff @(posedge aclk) low_q <= (rd_n && wr_n) ? 6'h00 : low_q + 6'h01;
   a_strobe_len: assert property ($rose(rd_n && wr_n) |->
      low_q == 6'h06 || low_q == 6'h1E) else $error("bad strobe length");
   a_ack_on_end: assert property ($rose(rd_n && wr_n) |-> ext_ack)
      else $error("no ack at strobe end");
   a_latch_first: assert property ($rose(port0_addr_oe) |-> ale_o && ale_oe)
      else $error("address without latch strobe");
   a_strobe_after: assert property ($fell(rd_n && wr_n) |->
      $past(ale_o && ale_oe)) else $error("strobe without latch");
   a_pull_high: assert property (ale_pullup_en != ale_oe)
      else $error("pull-up not tied to release");
   a_free_pulse: assert property (ale_o && ale_oe && !ext_req |=> !ale_o)
      else $error("free strobe too long");
   a_ack_pulse: assert property (ext_ack |=> !ext_ack)
      else $error("ack longer than one cycle");
   a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read answer late");
endmodule
bind auxc_aux_control auxc_aux_control_sva u_sva (.*);

// ### sim/aux_control_ale_gating_tb.sv
// self-checking bench for the auxiliary control register
module aux_control_ale_gating_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import auxc_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, double_speed_mode = 1'h0;
   logic ext_req = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rq[$], eq[$], e;
   logic [3:0] s_axi_wstrb = 4'hF;
   auxc_kind_t ext_kind = AUXC_XS_RD;
   logic [15:0] ext_addr = 16'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, ext_ack, ale_o, ale_oe, ale_pullup_en, rd_n, wr_n;
   logic port0_addr_oe, port_pullup_en, xram_select;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] port0_addr, mem_addr, mem_len, v;
   logic [10:0] xram_size_bytes;
   int err_count = 0, tests_run = 0, cyc = 0, n;
   auxc_aux_control DUT (.*);
   auxc_mem_model u_mem (.aclk(aclk), .ale_o(ale_o), .ale_oe(ale_oe),
      .rd_n(rd_n), .wr_n(wr_n), .port0_addr_oe(port0_addr_oe),
      .port0_addr(port0_addr), .addr_q(mem_addr), .len_q(mem_len));
   initial forever #2.5 aclk = ~aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         err_count++;
         $display("wrong value t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] d);
      s_axi_awaddr <= 12'h238;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      rq.push_back({24'h0, x});
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask
   // request held until ack is sampled high, then dropped
   task automatic ext(input auxc_kind_t k, input logic [7:0] len);
      ext_kind <= k;
      ext_addr <= 16'($urandom);
      ext_req <= 1'h1;
      @(posedge aclk);
      eq.push_back({16'h0, len, ext_addr[7:0]});
      while (!ext_ack) @(posedge aclk);
      ext_req <= 1'h0;
   endtask
   task automatic ale_count(input logic [7:0] d, input logic f, input int x);
      wr(d);
      double_speed_mode <= f;
      repeat (12) @(posedge aclk);
      n = 0;
      repeat (60) begin
         @(posedge aclk);
         n += int'(ale_o && ale_oe);
      end
      chk(32'(n), 32'(x));
   endtask
   // results are matched against the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata, rq.pop_front());
      if (ext_ack) begin
         e = eq.pop_front();
         chk({16'h0, e[15:8] != 8'h0 ? mem_len : 8'h0, mem_addr}, e);
      end
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(1));
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(12'h238, 8'h0C);
      chk(32'(xram_size_bytes), 32'h400);
      chk(32'({xram_select, port_pullup_en}), 32'h3);
      rd(12'h000, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom) & 8'hAF;
         v[3:2] = i[1:0];
         wr(v);
         rd(12'h238, v);
         chk(32'(xram_size_bytes), 32'(i % 4 + 1) * 32'h100);
         chk(32'({xram_select, port_pullup_en}), 32'({!v[1], !v[7]}));
      end
      $display("test fields done");
      for (int i = 0; i < 16; i++) begin
         wr({2'h0, i[2], 1'h0, 3'h7, i[3]});
         ext(auxc_kind_t'(i[1:0]), i[1] ? 8'h00 : (i[2] ? 8'h1E : 8'h06));
      end
      $display("test external done");
      ale_count(8'h0C, 1'h0, 6'd10);
      ale_count(8'h0C, 1'h1, 6'd20);
      ale_count(8'h0D, 1'h1, 6'd0);
      chk(32'(ale_pullup_en), 32'h1);
      $display("test latch strobe done");
      wrap_up();
   end
endmodule
